// file: rtl/ppm_defs.vh
// Constants for the peripheral port map and interrupt vector block
`ifndef PPM_DEFS_VH
`define PPM_DEFS_VH
// Port addresses
`define PPM_A_PORT_A_DATA 8'h00
`define PPM_A_PORT_A_DIR 8'h04
`define PPM_A_PORT_B_DATA 8'h08
`define PPM_A_PORT_B_DIR 8'h0c
`define PPM_A_PORT_C_DATA 8'h10
`define PPM_A_PORT_C_DIR 8'h14
`define PPM_A_PORT_D_DATA 8'h18
`define PPM_A_PORT_D_DIR 8'h1c
`define PPM_A_PORT_E_DATA 8'h20
`define PPM_A_PORT_E_DIR 8'h24
`define PPM_A_PORT_F_DATA 8'h28
`define PPM_A_PORT_G_DATA 8'h2c
`define PPM_A_CONV_DATA 8'h30
`define PPM_A_CONV_CTRL 8'h34
`define PPM_A_INT_CTRL 8'h38
`define PPM_A_INT_FLAGS 8'h39
`define PPM_A_T1_PERIOD 8'h3a
`define PPM_A_T1_COUNT 8'h3b
`define PPM_A_CLK_SPEED 8'h3d
`define PPM_A_T2_PERIOD 8'h3e
`define PPM_A_T2_COUNT 8'h3f
// Reset values
`define PPM_RST_DIR 8'h00
`define PPM_RST_16 16'h0000
`define PPM_RST_CONV_CTRL 4'h0
// Field widths and positions
`define PPM_W_CONV_CTRL 4
`define PPM_INT_MASK_LSB 0
`define PPM_INT_MASK_MSB 7
`define PPM_NUM_INT 8
// Program memory vector addresses
`define PPM_VEC_BASE 15'h7ff0
`define PPM_VEC_PROTECT 15'h7ffe
`define PPM_VEC_RESET 15'h7fff
`endif

// file: rtl/ppm_prio_pick.v
// Fixed-priority pick of the lowest-index pending interrupt
`timescale 1ns/1ps
`include "ppm_defs.vh"
module ppm_prio_pick (
    // Request vector, bit 0 highest
    input wire [7:0] req,
    // Result
    output reg any,
    output reg [2:0] idx
);
    integer i;
    always @*
    begin
        any = 1'b0;
        idx = 3'h0;
        for (i = `PPM_NUM_INT - 1; i >= 0; i = i - 1)
        begin
            if (req[i])
            begin
                any = 1'b1;
                idx = i[2:0];
            end
        end
    end
endmodule

// file: rtl/ppm_port_map.v
// Peripheral port register bank and interrupt vector selection
// What this block does
// R1: Writes use right-justified low bits only
// R2: Port write carries address and accumulator
// R3: Reads zero bits above location width
// R4: Converter data valid bits sit high
// R5: Port data registers undefined after reset
// R6: Direction registers reset zero, meaning inputs
// R7: Interrupt flags survive reset unchanged
// R8: Honour read-only and write-only access
// R9: Branch only when triggered and enabled
// R10: Vectors 0-7 at consecutive words from base
// R11: Fixed source priority, index zero highest
// R12: Reset vector is last program word
// R13: Protection word never used as vector
// R14: Per-interrupt mask bit gates the branch
// R15: Reset branch after reset release
// R16: Highest pending taken first, others stay
`timescale 1ns/1ps
`include "ppm_defs.vh"
module ppm_port_map (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Core port access
    input wire [7:0] port_addr,
    input wire port_wr,
    input wire port_rd,
    input wire [15:0] port_wdata,
    output reg [15:0] port_rdata_q,
    // Port pins, bidirectional A to E, each 8 bits packed
    input wire [39:0] pin_in,
    output reg [39:0] pin_out_q,
    output reg [39:0] pin_oe_n_q,
    // Input port F and output port G
    input wire [7:0] port_f_in,
    output reg [15:0] port_g_q,
    // Peripheral-facing register values
    output reg [15:0] conv_data_q,
    output reg [3:0] conv_ctrl_q,
    output reg [15:0] int_ctrl_q,
    output reg [15:0] clk_speed_q,
    output reg [15:0] t1_period_q,
    output reg [15:0] t2_period_q,
    // Timer countdown loads and current values
    output reg t1_load_q,
    output reg t2_load_q,
    output reg [15:0] t_load_val_q,
    input wire [15:0] t1_count,
    input wire [15:0] t2_count,
    // Interrupt events, one bit per source, bit 0 highest
    input wire [7:0] int_event,
    input wire int_allow,
    input wire int_ack,
    // Vector fetch request to program memory
    output reg vec_req_q,
    output reg [14:0] vec_addr_q,
    output reg [7:0] int_flags_q
);
    localparam ST_RESET = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_WAIT = 3'b100;

    reg [2:0] state_q;
    reg [39:0] dir_q;
    reg [39:0] data_q;
    reg [15:0] rdata_d;
    wire [7:0] enabled;
    wire pick_any;
    wire [2:0] pick_idx;
    // Bidirectional port index and its bit offset in the packed buses
    wire [2:0] sel;
    wire [5:0] sel_lsb;
    // Interrupt taken this cycle and the flag bit it consumes
    wire take_int;
    wire [7:0] served;

    // Which of the five bidirectional ports, or 7 for none
    function [2:0] port_sel;
        input [7:0] a;
        begin
            case (a)
                `PPM_A_PORT_A_DATA, `PPM_A_PORT_A_DIR: port_sel = 3'h0;
                `PPM_A_PORT_B_DATA, `PPM_A_PORT_B_DIR: port_sel = 3'h1;
                `PPM_A_PORT_C_DATA, `PPM_A_PORT_C_DIR: port_sel = 3'h2;
                `PPM_A_PORT_D_DATA, `PPM_A_PORT_D_DIR: port_sel = 3'h3;
                `PPM_A_PORT_E_DATA, `PPM_A_PORT_E_DIR: port_sel = 3'h4;
                default: port_sel = 3'h7;
            endcase
        end
    endfunction

    // Pin value seen on reads: driven bits from latch, others from pin
    function [7:0] pin_view;
        input [7:0] dir;
        input [7:0] lat;
        input [7:0] pin;
        begin
            pin_view = (dir & lat) | (~dir & pin);
        end
    endfunction

    assign enabled = int_flags_q
        & int_ctrl_q[`PPM_INT_MASK_MSB:`PPM_INT_MASK_LSB]; // R9 R14

    // Offset only meaningful for the five bidirectional ports
    assign sel = port_sel(port_addr);
    assign sel_lsb = {sel, 3'b000};

    assign take_int = state_q == ST_RUN && int_allow && pick_any; // R9
    assign served = take_int ? 8'h01 << pick_idx : 8'h00; // R16

    ppm_prio_pick u_pick (
        .req(enabled),
        .any(pick_any),
        .idx(pick_idx)
    ); // R11 R16

    // Read mux, right-justified with zero fill
    always @*
    begin
        rdata_d = `PPM_RST_16; // R3
        case (port_addr)
            `PPM_A_PORT_A_DATA,
            `PPM_A_PORT_B_DATA,
            `PPM_A_PORT_C_DATA,
            `PPM_A_PORT_D_DATA,
            `PPM_A_PORT_E_DATA:
                rdata_d[7:0] = pin_view(dir_q[sel_lsb +: 8],
                    data_q[sel_lsb +: 8], pin_in[sel_lsb +: 8]); // R3
            `PPM_A_PORT_A_DIR,
            `PPM_A_PORT_B_DIR,
            `PPM_A_PORT_C_DIR,
            `PPM_A_PORT_D_DIR,
            `PPM_A_PORT_E_DIR:
                rdata_d[7:0] = dir_q[sel_lsb +: 8]; // R6
            `PPM_A_PORT_F_DATA: rdata_d[7:0] = port_f_in;
            `PPM_A_PORT_G_DATA: rdata_d = port_g_q;
            `PPM_A_CONV_CTRL:
                rdata_d[`PPM_W_CONV_CTRL-1:0] = conv_ctrl_q; // R3
            `PPM_A_INT_CTRL: rdata_d = int_ctrl_q;
            `PPM_A_INT_FLAGS: rdata_d[7:0] = int_flags_q;
            `PPM_A_T1_PERIOD: rdata_d = t1_period_q;
            `PPM_A_T1_COUNT: rdata_d = t1_count;
            `PPM_A_T2_PERIOD: rdata_d = t2_period_q;
            `PPM_A_T2_COUNT: rdata_d = t2_count;
            // Write-only converter data and clock speed read as zero
            default: rdata_d = `PPM_RST_16; // R8
        endcase
    end

    // Port data latches carry no reset; their value is undefined
    always @(posedge core_clk)
    begin
        if (port_wr)
        begin
            case (port_addr)
                `PPM_A_PORT_A_DATA,
                `PPM_A_PORT_B_DATA,
                `PPM_A_PORT_C_DATA,
                `PPM_A_PORT_D_DATA,
                `PPM_A_PORT_E_DATA:
                    data_q[sel_lsb +: 8] <= port_wdata[7:0]; // R1 R2 R5
                // Other locations live in the reset-carrying process
                default: data_q <= data_q;
            endcase
        end
    end

    // Interrupt flags carry no reset: they keep their pre-reset value
    // Served bit is consumed even when software writes the same cycle,
    // so one event never produces two vector fetches
    always @(posedge core_clk)
    begin
        if (port_wr && port_addr == `PPM_A_INT_FLAGS)
            int_flags_q <= (port_wdata[7:0] & ~served) | int_event; // R7
        else
            int_flags_q <= (int_flags_q & ~served) | int_event; // R16
    end

    // Reset-carrying registers and pin drivers
    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dir_q <= {5{`PPM_RST_DIR}}; // R6
            pin_out_q <= {5{`PPM_RST_DIR}};
            pin_oe_n_q <= {40{1'b1}}; // R6
            port_g_q <= `PPM_RST_16;
            conv_data_q <= `PPM_RST_16;
            conv_ctrl_q <= `PPM_RST_CONV_CTRL;
            int_ctrl_q <= `PPM_RST_16;
            clk_speed_q <= `PPM_RST_16;
            t1_period_q <= `PPM_RST_16;
            t2_period_q <= `PPM_RST_16;
            t1_load_q <= 1'b0;
            t2_load_q <= 1'b0;
            t_load_val_q <= `PPM_RST_16;
            port_rdata_q <= `PPM_RST_16;
        end
        else
        begin
            pin_out_q <= data_q;
            pin_oe_n_q <= ~dir_q;
            t1_load_q <= 1'b0;
            t2_load_q <= 1'b0;
            if (port_rd)
                port_rdata_q <= rdata_d;
            if (port_wr)
            begin
                t_load_val_q <= port_wdata;
                case (port_addr)
                    `PPM_A_PORT_A_DIR,
                    `PPM_A_PORT_B_DIR,
                    `PPM_A_PORT_C_DIR,
                    `PPM_A_PORT_D_DIR,
                    `PPM_A_PORT_E_DIR:
                        dir_q[sel_lsb +: 8] <= port_wdata[7:0]; // R1
                    `PPM_A_PORT_G_DATA: port_g_q <= port_wdata;
                    // Valid value occupies the upper bits as written
                    `PPM_A_CONV_DATA: conv_data_q <= port_wdata; // R4
                    `PPM_A_CONV_CTRL:
                        conv_ctrl_q <=
                            port_wdata[`PPM_W_CONV_CTRL-1:0]; // R1
                    `PPM_A_INT_CTRL: int_ctrl_q <= port_wdata;
                    `PPM_A_CLK_SPEED: clk_speed_q <= port_wdata;
                    `PPM_A_T1_PERIOD: t1_period_q <= port_wdata;
                    `PPM_A_T1_COUNT: t1_load_q <= 1'b1;
                    `PPM_A_T2_PERIOD: t2_period_q <= port_wdata;
                    `PPM_A_T2_COUNT: t2_load_q <= 1'b1;
                    // Port F is read-only; writes are dropped
                    default: port_g_q <= port_g_q; // R8
                endcase
            end
        end
    end

    // Vector sequencing: reset branch first, then interrupts
    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= ST_RESET;
            vec_req_q <= 1'b0;
            vec_addr_q <= `PPM_VEC_RESET;
        end
        else
        begin
            case (state_q)
                ST_RESET:
                begin
                    vec_req_q <= 1'b1; // R15
                    vec_addr_q <= `PPM_VEC_RESET; // R12
                    state_q <= ST_WAIT;
                end
                ST_RUN:
                begin
                    if (take_int) // R9
                    begin
                        vec_req_q <= 1'b1;
                        vec_addr_q <= `PPM_VEC_BASE
                            + {12'h000, pick_idx}; // R10 R13
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    if (int_ack)
                    begin
                        vec_req_q <= 1'b0;
                        state_q <= ST_RUN;
                    end
                end
                default: state_q <= ST_RESET;
            endcase
        end
    end
endmodule

// file: tb/ppm_port_map_assertions.sv
// Port map block assertions
`timescale 1ns/1ps
module ppm_port_map_assertions (
    // Clock and reset
    input wire core_clk,
    input wire rstn,
    // Watched ports
    input wire [39:0] pin_oe_n_q,
    input wire [15:0] int_ctrl_q,
    input wire int_ack,
    input wire [7:0] int_event,
    input wire vec_req_q,
    input wire [14:0] vec_addr_q,
    input wire [7:0] int_flags_q
);
    reg [7:0] pm_q;
    reg [7:0] pf_q;
    wire [2:0] ix = vec_addr_q[2:0];
    // Mask and flags as seen at the decision edge
    always @(posedge core_clk) pm_q <= int_ctrl_q[7:0];
    always @(posedge core_clk) pf_q <= int_flags_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence took;
        $rose(vec_req_q) && !vec_addr_q[3];
    endsequence
    a_reset_fetch: assert property ($rose(rstn) |=>
        vec_req_q && vec_addr_q == 15'h7fff) else $error("no reset fetch");
    a_dir_reset: assert property (disable iff (1'b0)
        !rstn |-> &pin_oe_n_q) else $error("pins driven in reset");
    a_vec_legal: assert property (vec_req_q |->
        vec_addr_q == 15'h7fff || vec_addr_q[14:3] == 12'hffe)
        else $error("bad vector address");
    a_req_hold: assert property (vec_req_q && !int_ack |=>
        vec_req_q && $stable(vec_addr_q)) else $error("request lost");
    a_ack_drop: assert property (vec_req_q && int_ack |=>
        !vec_req_q) else $error("request kept after fetch");
    a_mask_gate: assert property (took |->
        pf_q[ix] && pm_q[ix]) else $error("vector not enabled");
    a_prio_first: assert property (took |->
        (pf_q & pm_q & ((8'h01 << ix) - 8'h01)) == 8'h00)
        else $error("lower priority taken first");
    a_flag_clear: assert property (took |->
        !int_flags_q[ix] || $past(int_event[ix]))
        else $error("served flag kept");
    c_took: cover property (took);
    c_reset: cover property ($rose(rstn) ##1 vec_req_q);
    c_wait: cover property ((vec_req_q && !int_ack) [*3]);
endmodule
bind ppm_port_map ppm_port_map_assertions ppm_port_map_assertions_inst (
    .core_clk(core_clk), .rstn(rstn), .pin_oe_n_q(pin_oe_n_q),
    .int_ctrl_q(int_ctrl_q), .int_ack(int_ack), .int_event(int_event),
    .vec_req_q(vec_req_q),
    .vec_addr_q(vec_addr_q), .int_flags_q(int_flags_q)
);

// file: tb/ppm_core_model.sv
// Core model answering vector fetch requests
`timescale 1ns/1ps
module ppm_core_model (
    // Clock, request and fetch delay
    input wire core_clk,
    input wire vec_req_q,
    input wire [3:0] ack_wait,
    // Vector fetched
    output reg int_ack = 1'b0
);
    integer n = 0;
    // One-cycle fetch pulse after ack_wait pending cycles
    always @(negedge core_clk)
    begin
        int_ack <= vec_req_q === 1'b1 && !int_ack && n >= ack_wait;
        n <= (vec_req_q === 1'b1 && !int_ack) ? n + 1 : 0;
    end
endmodule

// file: tb/ppm_port_map_tb_top.sv
// Self-checking bench for the port map block
`timescale 1ns/1ps
module ppm_port_map_tb_top;
    reg core_clk = 1'b0, rstn = 1'b1, port_wr = 1'b0, port_rd = 1'b0;
    reg int_allow = 1'b0;
    reg [7:0] port_addr = 8'h00, port_f_in = 8'h00, int_event = 8'h00;
    reg [15:0] port_wdata = 16'h0000, t1_count = 16'h0000;
    reg [15:0] t2_count = 16'h0000;
    reg [39:0] pin_in = 40'h0;
    reg [3:0] ack_wait = 4'h0;
    wire [15:0] port_rdata_q, conv_data_q, port_g_q, int_ctrl_q;
    wire [15:0] clk_speed_q, t1_period_q, t2_period_q, t_load_val_q;
    wire [7:0] int_flags_q;
    wire [3:0] conv_ctrl_q;
    wire t1_load_q, t2_load_q;
    wire [39:0] pin_out_q, pin_oe_n_q;
    wire [14:0] vec_addr_q;
    wire int_ack, vec_req_q;
    integer err_total = 0, n_tests = 0, i, k;
    reg [15:0] d;
    reg [7:0] e;
    reg [14:0] got[$], exp_q[$];
    reg [7:0] ra[0:9] = '{8'h04, 8'h0c, 8'h14, 8'h1c, 8'h24,
        8'h2c, 8'h34, 8'h38, 8'h3a, 8'h3e};
    ppm_port_map ppm_port_map_inst (
        .core_clk(core_clk), .rstn(rstn), .port_addr(port_addr),
        .port_wr(port_wr), .port_rd(port_rd), .port_wdata(port_wdata),
        .port_rdata_q(port_rdata_q), .pin_in(pin_in),
        .pin_out_q(pin_out_q), .pin_oe_n_q(pin_oe_n_q),
        .port_f_in(port_f_in), .port_g_q(port_g_q),
        .conv_data_q(conv_data_q), .conv_ctrl_q(conv_ctrl_q),
        .int_ctrl_q(int_ctrl_q), .clk_speed_q(clk_speed_q),
        .t1_period_q(t1_period_q), .t2_period_q(t2_period_q),
        .t1_load_q(t1_load_q), .t2_load_q(t2_load_q),
        .t_load_val_q(t_load_val_q), .t1_count(t1_count),
        .t2_count(t2_count), .int_event(int_event),
        .int_allow(int_allow), .int_ack(int_ack), .vec_req_q(vec_req_q),
        .vec_addr_q(vec_addr_q), .int_flags_q(int_flags_q)
    );
    ppm_core_model ppm_core_model_inst (
        .core_clk(core_clk), .vec_req_q(vec_req_q), .ack_wait(ack_wait),
        .int_ack(int_ack)
    );
    initial forever #50 core_clk = ~core_clk;
    // Record each fetched vector
    always @(posedge core_clk)
        if (vec_req_q === 1'b1 && int_ack === 1'b1)
            got.push_back(vec_addr_q);
    task chk(input [15:0] g, input [15:0] x);
        n_tests++;
        if (g !== x)
        begin
            err_total++;
            $display("wrong value at %0t: %h not %h", $time, g, x);
        end
    endtask
    task report_and_stop;
        $display("checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Port write (w=1) or read compared with x (w=0)
    task acc(input [7:0] a, input w, input [15:0] x);
        @(negedge core_clk);
        port_addr = a;
        port_wdata = x;
        port_wr = w;
        port_rd = !w;
        @(negedge core_clk);
        port_wr = 1'b0;
        port_rd = 1'b0;
        if (!w)
        begin
            @(negedge core_clk);
            chk(port_rdata_q, x);
        end
    endtask
    task wt(input integer n);
        integer j;
        for (j = 0; j < 300 && got.size() < n; j++)
            @(negedge core_clk);
        if (got.size() < n)
        begin
            $display("wrong value at %0t: vector fetch timed out", $time);
            err_total++;
            report_and_stop;
        end
    endtask
    task rst;
        rstn = 1'b0;
        repeat (6) @(negedge core_clk);
        rstn = 1'b1;
        got.delete();
        wt(1);
        chk(got.pop_front(), 15'h7fff);
    endtask
    initial
    begin
        // Let every process start so the reset edge is seen
        #1;
        void'($urandom(32'hbd2f5759));
        pin_in = {$urandom, $urandom};
        port_f_in = $urandom;
        t1_count = $urandom;
        t2_count = $urandom;
        rst;
        for (i = 0; i < 10; i++)
            acc(ra[i], 0, 16'h0000);
        $display("reset values done");
        for (i = 0; i < 10; i++)
        begin
            d = $urandom;
            acc(ra[i], 1, d);
            d &= i < 5 ? 16'h00ff : (i == 6 ? 16'h000f : 16'hffff);
            acc(ra[i], 0, d);
            if (i < 5)
                chk({8'h00, pin_oe_n_q[i*8 +: 8]}, {8'h00, ~d[7:0]});
            case (ra[i])
                8'h2c: chk(port_g_q, d);
                8'h34: chk({12'h000, conv_ctrl_q}, d);
                8'h38: chk(int_ctrl_q, d);
                8'h3a: chk(t1_period_q, d);
                8'h3e: chk(t2_period_q, d);
                default: ;
            endcase
        end
        $display("read back done");
        d = $urandom;
        acc(8'h04, 1, 16'hffff);
        acc(8'h00, 1, d);
        acc(8'h00, 0, {8'h00, d[7:0]});
        chk({pin_oe_n_q[7:0], pin_out_q[7:0]}, {8'h00, d[7:0]});
        acc(8'h04, 1, 16'h0000);
        acc(8'h00, 0, {8'h00, pin_in[7:0]});
        chk({8'h00, pin_oe_n_q[7:0]}, 16'h00ff);
        acc(8'h30, 1, d);
        chk(conv_data_q, d);
        acc(8'h30, 0, 16'h0000);
        acc(8'h3d, 1, d);
        chk(clk_speed_q, d);
        acc(8'h3d, 0, 16'h0000);
        acc(8'h28, 1, d);
        acc(8'h28, 0, {8'h00, port_f_in});
        acc(8'h3b, 0, t1_count);
        acc(8'h3f, 0, t2_count);
        acc(8'h3b, 1, d);
        chk({14'h0000, t1_load_q, t2_load_q}, 16'h0002);
        chk(t_load_val_q, d);
        acc(8'h3f, 1, ~d);
        chk({14'h0000, t1_load_q, t2_load_q}, 16'h0001);
        chk(t_load_val_q, ~d);
        acc(8'h3c, 0, 16'h0000);
        $display("access kinds done");
        e = $urandom;
        acc(8'h38, 1, 16'h0000);
        acc(8'h39, 1, {8'h00, e});
        rst;
        acc(8'h39, 0, {8'h00, e});
        chk({8'h00, int_flags_q}, {8'h00, e});
        $display("flag retention done");
        for (i = 0; i < 8; i++)
        begin
            {d, e} = $urandom;
            d[i] = 1'b1;
            e[i] = 1'b1;
            ack_wait = $urandom;
            acc(8'h39, 1, 16'h0000);
            acc(8'h38, 1, d);
            int_event = e;
            @(negedge core_clk);
            int_event = 8'h00;
            int_allow = 1'b1;
            for (k = 0; k < 8; k++)
                if (e[k] & d[k])
                    exp_q.push_back(15'h7ff0 + k);
            wt(exp_q.size());
            repeat (20) @(negedge core_clk);
            chk(got.size(), exp_q.size());
            while (got.size() && exp_q.size())
                chk(got.pop_front(), exp_q.pop_front());
            got.delete();
            exp_q.delete();
            int_allow = 1'b0;
            acc(8'h39, 0, {8'h00, e & ~d[7:0]});
        end
        $display("interrupts done");
        report_and_stop;
    end
endmodule
